// ### design/fsw_pkg.sv
// Function
// - The output goes low once the sampled field rises above the operate threshold.
// - The output goes high once the field falls below the release threshold; the gap is the hysteresis.
// - Powering up with the field inside the band leaves the output high until the first excursion.
// - Field movement inside the band never changes the output.
// - After supply is good the output is held low for the power-on delay, then follows the field.
// - Self-test runs only while the enable input is held high; otherwise normal switching resumes.
// - In self-test a stimulus between the lower and upper reference, with both thresholds inside their drift window, gives a 50% duty pulse output.
// - In self-test a stimulus outside the references gives a fixed output level.
// - In self-test a threshold outside 0.25 to 1.75 times its nominal gives a fixed output level.
// - The self-test pulse output uses a carrier of about 3 kHz.
// - After self-test enable falls a valid switch output appears within 25 us.
package fsw_pkg;
	localparam int          FW         = 12;
	localparam int          CLK_MHZ    = 100;
	localparam int          PWM_HZ     = 3000;
	localparam int          PWM_HALF   = (CLK_MHZ * 1000000) / (PWM_HZ * 2);
	localparam int          CW         = 16;
	localparam int          TON_US     = 25;
	localparam int          TON_CYC    = TON_US * CLK_MHZ;
	localparam int          REC_US     = 25;
	localparam int          REC_CYC    = REC_US * CLK_MHZ;
	localparam int          STEP_G     = 5;
	localparam int          BOP_MAX_G  = 250;
	localparam int          BRP_MIN_G  = -5;
	localparam logic [11:0] HYS_MIN0   = 12'h005;
	localparam logic [11:0] HYS_MAX0   = 12'h01e;
	localparam logic [11:0] HYS_MIN1   = 12'h007;
	localparam logic [11:0] HYS_MAX1   = 12'h028;
	localparam logic [11:0] HYS_MIN2   = 12'h00a;
	localparam logic [11:0] HYS_MAX2   = 12'h03c;
	localparam logic [11:0] HYS_MIN3   = 12'h00f;
	localparam logic [11:0] HYS_MAX3   = 12'h041;
	localparam logic        OUT_RESET  = 1'b0;
	typedef enum logic [1:0] {
		FSW_POWERUP = 2'b00,
		FSW_NORMAL  = 2'b01,
		FSW_TEST    = 2'b10
	} fsw_mode_e;
endpackage

// ### design/fsw_switch.sv
`timescale 1ns/1ns
// Field threshold switch with on-demand self-test
module fsw_switch (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        self_test_enable,
	input  wire logic signed [fsw_pkg::FW-1:0] field,
	input  wire logic signed [fsw_pkg::FW-1:0] operate_threshold,
	input  wire logic signed [fsw_pkg::FW-1:0] release_threshold,
	input  wire logic signed [fsw_pkg::FW-1:0] operate_nominal,
	input  wire logic signed [fsw_pkg::FW-1:0] release_nominal,
	input  wire logic        [1:0]           hysteresis_select,
	input  wire logic signed [fsw_pkg::FW-1:0] stimulus,
	input  wire logic signed [fsw_pkg::FW-1:0] ref_lower,
	input  wire logic signed [fsw_pkg::FW-1:0] ref_upper,
	output logic                             switch_output,
	output logic                             test_fail,
	output logic                             config_valid,
	output logic                             output_valid
);
	logic                    st_en;
	fsw_pkg::fsw_mode_e      mode;
	logic [fsw_pkg::CW-1:0]  on_cnt;
	logic [fsw_pkg::CW-1:0]  pwm_cnt;
	logic                    pwm;
	logic                    latch;
	logic                    first_done;
	logic                    st_fail;
	logic                    drift_bad;
	logic                    stim_ok;
	logic signed [fsw_pkg::FW+2:0] op_x4;
	logic signed [fsw_pkg::FW+2:0] rp_x4;
	logic signed [fsw_pkg::FW+2:0] opn;
	logic signed [fsw_pkg::FW+2:0] rpn;
	logic signed [fsw_pkg::FW:0]   hys;
	logic [11:0]             hmin;
	logic [11:0]             hmax;

	// Pin input crosses into the clock domain
	fsw_sync u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     (self_test_enable),
		.q     (st_en)
	);

	// Mode sequencing: power-up, normal, self-test
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mode   <= fsw_pkg::FSW_POWERUP;
			on_cnt <= '0;
		end
		else
		begin
			case (mode)
				fsw_pkg::FSW_POWERUP:
				begin
					on_cnt <= on_cnt + 1'b1;
					if (on_cnt == fsw_pkg::CW'(fsw_pkg::TON_CYC - 1))
						mode <= fsw_pkg::FSW_NORMAL;
				end
				fsw_pkg::FSW_NORMAL:
					if (st_en)
						mode <= fsw_pkg::FSW_TEST;
				fsw_pkg::FSW_TEST:
					if (!st_en)
						mode <= fsw_pkg::FSW_NORMAL;
				default:
					mode <= fsw_pkg::FSW_POWERUP;
			endcase
		end
	end

	// Hysteresis band limits per select code
	always_comb
	begin
		case (hysteresis_select)
			2'b00:
			begin
				hmin = fsw_pkg::HYS_MIN0;
				hmax = fsw_pkg::HYS_MAX0;
			end
			2'b01:
			begin
				hmin = fsw_pkg::HYS_MIN1;
				hmax = fsw_pkg::HYS_MAX1;
			end
			2'b10:
			begin
				hmin = fsw_pkg::HYS_MIN2;
				hmax = fsw_pkg::HYS_MAX2;
			end
			default:
			begin
				hmin = fsw_pkg::HYS_MIN3;
				hmax = fsw_pkg::HYS_MAX3;
			end
		endcase
	end

	// Threshold programming checks
	assign hys = (fsw_pkg::FW+1)'(operate_threshold) - (fsw_pkg::FW+1)'(release_threshold);
	assign config_valid = (operate_threshold <= (fsw_pkg::FW)'(fsw_pkg::BOP_MAX_G))
		&& (operate_threshold % (fsw_pkg::FW)'(fsw_pkg::STEP_G) == '0)
		&& (operate_threshold >= (fsw_pkg::FW)'(fsw_pkg::BRP_MIN_G) + $signed({1'b0, hmin[10:0]}))
		&& (hys >= $signed({1'b0, hmin})) && (hys <= $signed({1'b0, hmax}));

	// Drift window 0.25x to 1.75x nominal, in quarters
	assign op_x4 = (fsw_pkg::FW+3)'(operate_threshold) <<< 2;
	assign rp_x4 = (fsw_pkg::FW+3)'(release_threshold) <<< 2;
	assign opn   = (fsw_pkg::FW+3)'(operate_nominal);
	assign rpn   = (fsw_pkg::FW+3)'(release_nominal);
	assign drift_bad = (op_x4 < opn) || (op_x4 > opn * 15'sh007)
		|| (rp_x4 < rpn) || (rp_x4 > rpn * 15'sh007);
	assign stim_ok  = (stimulus > ref_lower) && (stimulus < ref_upper);
	assign st_fail  = !stim_ok || drift_bad;

	// Hysteresis latch of the field comparison
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			latch      <= 1'b1;
			first_done <= 1'b0;
		end
		else if (field > operate_threshold)
		begin
			latch      <= 1'b0;
			first_done <= 1'b1;
		end
		else if (field < release_threshold)
		begin
			latch      <= 1'b1;
			first_done <= 1'b1;
		end
		// Inside band: hold, high after power-up
	end

	// 3 kHz carrier, reset on self-test entry
	always_ff @(posedge clk)
	begin
		if (!rst_n || mode != fsw_pkg::FSW_TEST)
		begin
			pwm_cnt <= '0;
			pwm     <= 1'b1;
		end
		else if (pwm_cnt == fsw_pkg::CW'(fsw_pkg::PWM_HALF - 1))
		begin
			pwm_cnt <= '0;
			pwm     <= !pwm;
		end
		else
			pwm_cnt <= pwm_cnt + 1'b1;
	end

	// Output drive and failure flag
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			switch_output <= fsw_pkg::OUT_RESET;
			test_fail     <= 1'b0;
		end
		else
		begin
			case (mode)
				fsw_pkg::FSW_POWERUP: switch_output <= 1'b0;
				fsw_pkg::FSW_TEST:    switch_output <= st_fail ? stim_ok || (stimulus >= ref_upper) : pwm;
				default:              switch_output <= latch;
			endcase
			test_fail <= (mode == fsw_pkg::FSW_TEST) && st_fail;
		end
	end
	assign output_valid = (mode == fsw_pkg::FSW_NORMAL);

	// Checks
	AST_PWR_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		$past(mode) == fsw_pkg::FSW_POWERUP && mode == fsw_pkg::FSW_POWERUP |-> !switch_output)
		else $error("output not low during power-up");
	AST_PWR_END: assert property (@(posedge clk) disable iff (!rst_n)
		mode == fsw_pkg::FSW_POWERUP && on_cnt == fsw_pkg::CW'(fsw_pkg::TON_CYC - 1)
		|=> mode == fsw_pkg::FSW_NORMAL)
		else $error("power-up delay wrong length");
	AST_OPERATE: assert property (@(posedge clk) disable iff (!rst_n)
		mode == fsw_pkg::FSW_NORMAL && field > operate_threshold ##1 mode == fsw_pkg::FSW_NORMAL |=> !switch_output)
		else $error("output not low above operate");
	AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
		mode == fsw_pkg::FSW_NORMAL && field < release_threshold ##1 mode == fsw_pkg::FSW_NORMAL |=> switch_output)
		else $error("output not high below release");
	AST_BAND_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		$stable(mode) && mode == fsw_pkg::FSW_NORMAL && $past(mode) == fsw_pkg::FSW_NORMAL
		&& $past(field) <= $past(operate_threshold) && $past(field) >= $past(release_threshold)
		&& $past(latch) == $past(switch_output) |=> $stable(switch_output))
		else $error("output moved inside band");
	AST_BAND_START: assert property (@(posedge clk) disable iff (!rst_n)
		mode == fsw_pkg::FSW_NORMAL && $past(mode) == fsw_pkg::FSW_NORMAL && !first_done |-> switch_output)
		else $error("band start not high");
	AST_TEST_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
		mode == fsw_pkg::FSW_NORMAL && st_en |=> mode == fsw_pkg::FSW_TEST)
		else $error("self-test not entered");
	AST_TEST_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
		mode == fsw_pkg::FSW_TEST && !st_en |=> mode == fsw_pkg::FSW_NORMAL ##1 switch_output == $past(latch))
		else $error("self-test exit slow");
	AST_PASS_START: assert property (@(posedge clk) disable iff (!rst_n)
		$past(mode) == fsw_pkg::FSW_NORMAL && mode == fsw_pkg::FSW_TEST && !st_fail |=> switch_output)
		else $error("pulse output not started high");
	AST_FAIL_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
		mode == fsw_pkg::FSW_TEST && st_fail |=> test_fail)
		else $error("failure flag missing");
	AST_FAIL_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		mode != fsw_pkg::FSW_TEST |=> !test_fail)
		else $error("failure flag outside self-test");
	AST_FAIL_FIXED: assert property (@(posedge clk) disable iff (!rst_n)
		mode == fsw_pkg::FSW_TEST && drift_bad && $stable(stimulus) ##1 mode == fsw_pkg::FSW_TEST && drift_bad
		&& $stable(stimulus) |=> $stable(switch_output))
		else $error("output pulses on failure");
	AST_PWM_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
		mode == fsw_pkg::FSW_TEST && pwm_cnt == fsw_pkg::CW'(fsw_pkg::PWM_HALF - 1) |=> pwm != $past(pwm))
		else $error("carrier half period wrong");

	// Main scenarios reached
	COV_OPERATE: cover property (@(posedge clk) mode == fsw_pkg::FSW_NORMAL && $fell(switch_output));
	COV_TEST:    cover property (@(posedge clk) mode == fsw_pkg::FSW_TEST && $rose(pwm));
	COV_FAIL:    cover property (@(posedge clk) $rose(test_fail));
	COV_EXIT:    cover property (@(posedge clk) $past(mode) == fsw_pkg::FSW_TEST && mode == fsw_pkg::FSW_NORMAL);
endmodule

// ### design/fsw_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for a pin input
module fsw_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic meta;

	// First flop feeds only the second
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta <= 1'b0;
			q    <= 1'b0;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ### test/fsw_ctrl_model.sv
`timescale 1ns/1ns
// Far-side controller: raises the self-test pin and judges the output duty
module fsw_ctrl_model #(
	parameter int SETTLE = 100000
) (
	input  wire logic clk,
	input  wire logic req,
	input  wire logic switch_output,
	output logic      self_test_enable = 1'b0,
	output logic      duty_pass
);
	int age = 0;
	int hi  = 0;
	int lo  = 0;
	logic req_q = 1'b0;
	// Request taken on the rising edge, clear of the bench's falling-edge writes
	always @(posedge clk)
		req_q <= req;
	// Pin follows the request, moved on the falling edge
	always @(negedge clk)
		self_test_enable <= req_q;
	// Levels counted only once the pin has settled
	always @(posedge clk)
	begin
		if (!self_test_enable)
		begin
			age <= 0;
			hi  <= 0;
			lo  <= 0;
		end
		else if (age < SETTLE)
			age <= age + 1;
		else if (switch_output)
			hi <= hi + 1;
		else
			lo <= lo + 1;
	end
	// Pass only for a duty inside the accepted window
	assign duty_pass = (hi + lo > 0) && (hi * 100 >= (hi + lo) * 40) && (hi * 100 <= (hi + lo) * 60);
endmodule

// ### test/fsw_switch_tb.sv
`timescale 1ns/1ns
// Self-checking bench for the field switch
module fsw_switch_tb;
	logic                      clk = 1'b0;
	logic                      rst_n = 1'b0;
	logic                      req = 1'b0;
	logic                      st_en;
	logic signed [11:0]        field = 12'sh05a;
	logic signed [11:0]        op = 12'sh064;
	logic signed [11:0]        rel = 12'sh050;
	logic signed [11:0]        op_nom = 12'sh064;
	logic signed [11:0]        rel_nom = 12'sh050;
	logic        [1:0]         hsel = 2'h0;
	logic signed [11:0]        stim = 12'sh000;
	logic signed [11:0]        ref_lo = 12'shff6;
	logic signed [11:0]        ref_hi = 12'sh00a;
	logic                      so;
	logic                      tf;
	logic                      cv;
	logic                      ov;
	logic                      duty_pass;
	int                        error_cnt = 0;
	int                        total_checks = 0;
	int                        seed = 66;
	int                        m = 1;
	int                        sv[4] = '{20, -20, 0, 0};
	int                        nv[4] = '{100, 100, 10, 100};
	int                        rn[4] = '{80, 80, 80, 400};
	int                        hmin[4] = '{5, 7, 10, 15};
	int                        hmax[4] = '{30, 40, 60, 65};
	logic                      ev[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
	// Clock at 100 MHz
	always #5 clk = ~clk;
	fsw_switch uut (.clk(clk), .rst_n(rst_n), .self_test_enable(st_en), .field(field),
		.operate_threshold(op), .release_threshold(rel), .operate_nominal(op_nom),
		.release_nominal(rel_nom), .hysteresis_select(hsel), .stimulus(stim),
		.ref_lower(ref_lo), .ref_upper(ref_hi), .switch_output(so), .test_fail(tf),
		.config_valid(cv), .output_valid(ov));
	fsw_ctrl_model #(.SETTLE(10)) ctrl (.clk(clk), .req(req), .switch_output(so),
		.self_test_enable(st_en), .duty_pass(duty_pass));
	// Compare one bit
	task automatic cmp(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// New field, hysteresis model, settle, compare
	task automatic step(input int f);
		@(negedge clk);
		field = 12'(f);
		if (f > op)
			m = 0;
		else if (f < rel)
			m = 1;
		repeat (3) @(negedge clk);
		cmp(so, 1'(m));
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		repeat (2400) @(negedge clk);
		cmp(so, 1'b0);
		repeat (200) @(negedge clk);
		cmp(so, 1'b1);
		cmp(ov, 1'b1);
		foreach (sv[i])
			step(i == 0 ? 101 : i == 1 ? 100 : 79);
		step(80);
		repeat (40)
			step(50 + {$random(seed)} % 100);
		step(50);
		rel = 12'sh05c;
		for (int s = 0; s < 4; s++)
		begin
			hsel = 2'(s);
			@(negedge clk);
			cmp(cv, 1'(8 >= hmin[s] && 8 <= hmax[s]));
		end
		hsel = 2'h0;
		rel = 12'sh050;
		op = 12'sh067;
		@(negedge clk);
		cmp(cv, 1'b0);
		op = 12'sh064;
		req = 1'b1;
		repeat (33350) @(negedge clk);
		cmp(tf, 1'b0);
		cmp(ov, 1'b0);
		cmp(duty_pass, 1'b1);
		// Field crosses during self-test; the switch state must show on exit
		field = 12'sh08c;
		m = 0;
		req = 1'b0;
		repeat (5) @(negedge clk);
		cmp(ov, 1'b1);
		cmp(so, 1'(m));
		foreach (sv[i])
		begin
			stim = 12'(sv[i]);
			op_nom = 12'(nv[i]);
			rel_nom = 12'(rn[i]);
			req = 1'b1;
			repeat (12) @(negedge clk);
			cmp(tf, 1'b1);
			cmp(so, ev[i]);
			repeat (100) @(negedge clk);
			cmp(so, ev[i]);
			cmp(duty_pass, 1'b0);
			req = 1'b0;
			repeat (5) @(negedge clk);
		end
		step(40);
		report_and_stop();
	end
	// Watchdog well beyond the expected run
	initial
	begin
		#500000;
		error_cnt++;
		report_and_stop();
	end
endmodule
